/* File: design/bmx_core_regs.sv */
// bmx_core_regs: banked register file, status words and exception logic
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bmx_core_regs
  import bmx_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic [7:0] s_axi_awaddr, // write address
  output var logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  output var logic s_axi_wready, // write data ready
  output var logic s_axi_bvalid, // write response valid
  output var logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic [7:0] s_axi_araddr, // read address
  output var logic s_axi_arready, // read address ready
  output var logic s_axi_rvalid, // read data valid
  output var logic [31:0] s_axi_rdata, // read data
  output var logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rready, // read data ready
  input wire logic [3:0] rd_a_idx, // read port a index
  input wire logic [3:0] rd_b_idx, // read port b index
  output var logic [31:0] rd_a_data, // read port a data
  output var logic [31:0] rd_b_data, // read port b data
  input wire logic wr_en, // register write enable
  input wire logic [3:0] wr_idx, // register write index
  input wire logic [31:0] wr_data, // register write data
  input wire logic link_en, // call with link
  input wire logic pc_step, // advance program counter
  input wire logic csw_we, // status word write
  input wire bmx_csw_s csw_wdata, // status word value
  input wire logic ret_dp, // status-setting write to counter
  input wire logic ret_multi, // load_multiple_restore
  input wire bmx_exc_s exc_req, // exception requests
  input wire logic instr_valid, // instruction present
  input wire logic [31:0] instr, // instruction word
  input wire logic mem_req, // data access present
  input wire logic [31:0] mem_addr, // data access address
  input wire logic [1:0] mem_size, // data access size
  output var logic [31:0] pc, // program counter
  output var bmx_csw_s csw, // current_status_word
  output var logic privileged, // mode is not user
  output var logic fetch_half, // fetch 16-bit units
  output var logic cond_pass, // instruction may execute
  output var logic align_fault, // misaligned access seen
  output var logic exc_taken, // exception entered, pulse
  output var bmx_exc_s exc_class // class entered, one-hot
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // map mode and architectural index to physical slot
  function automatic logic [4:0] phys_idx(input logic [4:0] m, input logic [3:0] i);
    // user and system share one map
    phys_idx = {1'b0, i};
    if (m == MODE_FAST && i >= IDX_BANK_LO) begin
      phys_idx = PH_FAST + 5'(i - IDX_BANK_LO);
    end else if (i >= IDX_SP) begin
      case (m)
        MODE_SUP: phys_idx = PH_SUP + 5'(i - IDX_SP);
        MODE_ABT: phys_idx = PH_ABT + 5'(i - IDX_SP);
        MODE_UND: phys_idx = PH_UND + 5'(i - IDX_SP);
        MODE_IRQ: phys_idx = PH_IRQ + 5'(i - IDX_SP);
        default: phys_idx = {1'b0, i};
      endcase
    end
  endfunction : phys_idx

  // saved status slot of a mode; user and system have none
  function automatic logic [2:0] saved_idx(input logic [4:0] m);
    case (m)
      MODE_FAST: saved_idx = 3'h0;
      MODE_IRQ: saved_idx = 3'h1;
      MODE_SUP: saved_idx = 3'h2;
      MODE_ABT: saved_idx = 3'h3;
      MODE_UND: saved_idx = 3'h4;
      default: saved_idx = SAVED_NONE;
    endcase
  endfunction : saved_idx

  function automatic logic mode_ok(input logic [4:0] m);
    mode_ok = (m == MODE_USR) || (m == MODE_SYS) || (saved_idx(m) != SAVED_NONE);
  endfunction : mode_ok

  // condition field against the flags
  function automatic logic cond_ok(input logic [3:0] cc, input bmx_csw_s s);
    case (cc)
      4'h0: cond_ok = s.z;
      4'h1: cond_ok = !s.z;
      4'h2: cond_ok = s.c;
      4'h3: cond_ok = !s.c;
      4'h4: cond_ok = s.n;
      4'h5: cond_ok = !s.n;
      4'h6: cond_ok = s.v;
      4'h7: cond_ok = !s.v;
      4'h8: cond_ok = s.c && !s.z;
      4'h9: cond_ok = !s.c || s.z;
      4'hA: cond_ok = s.n == s.v;
      4'hB: cond_ok = s.n != s.v;
      4'hC: cond_ok = !s.z && (s.n == s.v);
      4'hD: cond_ok = s.z || (s.n != s.v);
      COND_AL: cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  endfunction : cond_ok

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0] gpr [NUM_PHYS]; // banked register storage
  bmx_csw_s saved [NUM_SAVED]; // saved_status_word per exception mode
  bmx_exc_s pend; // sticky abort, bad op and trap
  logic [1:0] ctrl; // exception enable, align-abort enable
  logic [4:0] peek_idx; // bus view into the register file
  logic [7:0] aw_addr; // captured write address
  logic [31:0] w_data; // captured write data
  logic [3:0] w_strb; // captured strobes

  ////////////////////////////////////////////////////////////////////////
  // combinational decisions

  logic [31:0] step; // fetch unit size
  logic [31:0] ret_addr; // address after current instruction
  logic misalign; // access off its natural boundary
  bmx_exc_s eff; // requests competing this cycle
  bmx_exc_s pick; // the one taken
  logic take; // exception entry this cycle
  logic [4:0] new_mode; // mode entered
  logic [31:0] new_vec; // vector entered
  logic has_saved; // current mode owns a saved word
  logic ret_ok; // exception return this cycle
  bmx_csw_s saved_cur; // saved word of current mode
  logic [31:0] lr_cur; // private link of current mode
  bmx_csw_s next_csw; // status word after this edge
  logic [31:0] next_pc; // counter after this edge

  assign step = csw.compact ? STEP_COMPACT : STEP_WIDE;
  assign ret_addr = pc + step;
  assign misalign = mem_req && (((mem_size == SZ_WORD) && (mem_addr[1:0] != 2'h0)) ||
                                ((mem_size == SZ_HALF) && mem_addr[0]));
  assign has_saved = saved_idx(csw.mode) != SAVED_NONE;
  assign saved_cur = has_saved ? saved[saved_idx(csw.mode)] : csw;
  assign lr_cur = gpr[phys_idx(csw.mode, IDX_LINK)];

  // five classes, masked interrupts stay off
  always_comb begin
    eff.abort = pend.abort || exc_req.abort || (ctrl[CTRL_ALIGN_AB] && misalign);
    eff.fast = exc_req.fast && !csw.fast_off;
    eff.irq = exc_req.irq && !csw.irq_off;
    eff.bad_op = pend.bad_op || exc_req.bad_op;
    eff.trap = pend.trap || exc_req.trap;
  end

  // abort, fast, irq, bad op, trap in that order
  always_comb begin
    pick = '0;
    new_mode = csw.mode;
    new_vec = pc;
    if (eff.abort) begin
      pick.abort = 1'b1;
      new_mode = MODE_ABT;
      new_vec = VEC_ABT;
    end else if (eff.fast) begin
      pick.fast = 1'b1;
      new_mode = MODE_FAST;
      new_vec = VEC_FAST;
    end else if (eff.irq) begin
      pick.irq = 1'b1;
      new_mode = MODE_IRQ;
      new_vec = VEC_IRQ;
    end else if (eff.bad_op) begin
      pick.bad_op = 1'b1;
      new_mode = MODE_UND;
      new_vec = VEC_UND;
    end else if (eff.trap) begin
      pick.trap = 1'b1;
      new_mode = MODE_SUP;
      new_vec = VEC_TRAP;
    end
  end

  // ctrl bit 0 lets software hold entry off, for bring-up
  assign take = ctrl[CTRL_EXC_EN] && (pick != '0);
  // return only from a mode with a saved word
  assign ret_ok = (ret_dp || ret_multi) && has_saved && !take;

  // next status word
  always_comb begin
    next_csw = csw;
    if (take) begin
      // mask on entry, state back to full width
      next_csw.mode = new_mode;
      next_csw.irq_off = 1'b1;
      next_csw.fast_off = csw.fast_off || pick.fast;
      next_csw.compact = 1'b0;
    end else if (ret_ok) begin
      next_csw = saved_cur;
    end else if (csw_we) begin
      // user mode may change flags only
      {next_csw.n, next_csw.z, next_csw.c, next_csw.v} =
        {csw_wdata.n, csw_wdata.z, csw_wdata.c, csw_wdata.v};
      if (csw.mode != MODE_USR) begin
        next_csw.irq_off = csw_wdata.irq_off;
        next_csw.fast_off = csw_wdata.fast_off;
        next_csw.compact = csw_wdata.compact;
        // undefined codes leave the mode unchanged
        if (mode_ok(csw_wdata.mode)) begin
          next_csw.mode = csw_wdata.mode;
        end
      end
    end
    next_csw.rsv = '0;
  end

  // next program counter
  always_comb begin
    if (take) begin
      next_pc = new_vec;
    end else if (ret_ok) begin
      next_pc = lr_cur;
    end else if (wr_en && wr_idx == IDX_PC) begin
      next_pc = wr_data;
    end else if (pc_step) begin
      next_pc = ret_addr;
    end else begin
      next_pc = pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status word, counter and derived outputs

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csw <= bmx_csw_s'(CSW_RST);
      privileged <= 1'b1;
      fetch_half <= 1'b0;
    end else begin
      csw <= next_csw;
      privileged <= next_csw.mode != MODE_USR;
      fetch_half <= next_csw.compact;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= PC_RST;
    end else begin
      pc <= next_pc;
    end
  end

  // save status word into entered mode slot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < NUM_SAVED; k++) begin
        saved[k] <= '0;
      end
    end else if (take) begin
      saved[saved_idx(new_mode)] <= csw;
    end else if (csw_we && has_saved && csw.mode != MODE_USR) begin
      // privileged software may also load its saved word directly
      // reserved bits kept zero, so a later return restores a clean word
      saved[saved_idx(csw.mode)] <= {csw_wdata.n, csw_wdata.z, csw_wdata.c, csw_wdata.v, 20'h00000, csw_wdata[7:0]};
    end
  end

  // 30 banked words plus counter, 16 visible
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < NUM_PHYS; k++) begin
        gpr[k] <= '0;
      end
    end else if (take) begin
      // entry writes only the private link
      gpr[phys_idx(new_mode, IDX_LINK)] <= ret_addr;
    end else if (!ret_ok) begin
      // call with link writes index 14
      if (link_en) begin
        gpr[phys_idx(csw.mode, IDX_LINK)] <= ret_addr;
      end
      if (wr_en && wr_idx != IDX_PC) begin
        gpr[phys_idx(csw.mode, wr_idx)] <= wr_data;
      end
    end
  end

  // sticky requests survive while others go first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= '0;
    end else begin
      pend.abort <= (pend.abort || exc_req.abort) && !(take && pick.abort);
      pend.bad_op <= (pend.bad_op || exc_req.bad_op) && !(take && pick.bad_op);
      pend.trap <= (pend.trap || exc_req.trap) && !(take && pick.trap);
      pend.fast <= 1'b0;
      pend.irq <= 1'b0;
    end
  end

  // read ports, one cycle after the index
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= (rd_a_idx == IDX_PC) ? pc : gpr[phys_idx(csw.mode, rd_a_idx)];
      rd_b_data <= (rd_b_idx == IDX_PC) ? pc : gpr[phys_idx(csw.mode, rd_b_idx)];
    end
  end

  // pipeline side flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cond_pass <= 1'b0;
      align_fault <= 1'b0;
      exc_taken <= 1'b0;
      exc_class <= '0;
    end else begin
      cond_pass <= instr_valid && (csw.compact || cond_ok(instr[31:28], csw));
      align_fault <= misalign;
      exc_taken <= take;
      exc_class <= take ? pick : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: address and data taken apart, answered together

  logic wr_go; // both halves held, no answer out
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write channels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_PEEK_IDX) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // software registers, low byte lane only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RST;
      peek_idx <= '0;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == ADDR_CTRL) begin
        ctrl <= w_data[1:0];
      end
      if (aw_addr == ADDR_PEEK_IDX) begin
        peek_idx <= w_data[4:0];
      end
    end
  end

  // read mux; unmapped answers an error with zero data
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL: rd_mux = {30'h00000000, ctrl};
      ADDR_CSW: rd_mux = csw;
      ADDR_PC: rd_mux = pc;
      ADDR_PEND: rd_mux = {27'h0000000, pend};
      ADDR_PEEK_IDX: rd_mux = {27'h0000000, peek_idx};
      // out-of-range slots read zero rather than wrap
      ADDR_PEEK_DATA: rd_mux = (peek_idx < 5'(NUM_PHYS)) ? gpr[peek_idx] : '0;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [31:0] step_q; // step of last cycle for the counter check
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_q <= STEP_WIDE;
    end else begin
      step_q <= step;
    end
  end

  priv_mode_a: assert property (privileged == (csw.mode != MODE_USR))
    else $error("privileged flag disagrees with mode");
  entry_save_a: assert property (take |=> saved[saved_idx(csw.mode)] == $past(csw))
    else $error("saved word not copied on entry");
  entry_mask_a: assert property (take |=> csw.irq_off && (csw.mode != MODE_FAST || csw.fast_off))
    else $error("interrupts not masked on entry");
  abort_first_a: assert property (take && eff.abort |=> csw.mode == MODE_ABT && exc_class.abort)
    else $error("abort did not win priority");
  return_a: assert property (ret_ok |=> csw == $past(saved_cur) && pc == $past(lr_cur))
    else $error("return did not restore state");
  pc_read_a: assert property (rd_a_idx == IDX_PC |=> rd_a_data == $past(pc))
    else $error("index 15 did not read counter");
  entry_link_a: assert property (take |=> lr_cur == $past(ret_addr) && exc_taken)
    else $error("private link not loaded on entry");
  pc_step_a: assert property (pc_step && !take && !ret_ok && !wr_en |=> pc == $past(pc) + step_q)
    else $error("counter step wrong for state");
  align_word_a: assert property (mem_req && mem_size == SZ_WORD && mem_addr[1:0] != 2'h0 |=> align_fault)
    else $error("misaligned word not flagged");
  cond_al_a: assert property (instr_valid && instr[31:28] == COND_AL |=> cond_pass)
    else $error("always condition did not pass");
  trap_kept_a: assert property (exc_req.trap && take && !pick.trap |=> pend.trap)
    else $error("trap request lost");

  fast_entry_c: cover property (take && pick.fast ##1 exc_taken);
  two_pend_c: cover property (take && eff.abort && eff.irq ##1 take && pick.irq);
  ret_seen_c: cover property (take ##[1:20] ret_ok);
  bus_err_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : bmx_core_regs
`default_nettype wire

/* File: design/bmx_pkg.sv */
// bmx_pkg: constants and types of the banked register and exception unit
package bmx_pkg;
  // mode field codes
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SUP = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h14;
  localparam logic [4:0] MODE_UND = 5'h15;
  localparam logic [4:0] MODE_SYS = 5'h16;
  // physical register file: 30 words plus the program counter
  localparam int NUM_PHYS = 30;
  localparam int NUM_SAVED = 5;
  localparam logic [4:0] PH_FAST = 5'h0F;
  localparam logic [4:0] PH_SUP = 5'h16;
  localparam logic [4:0] PH_ABT = 5'h18;
  localparam logic [4:0] PH_UND = 5'h1A;
  localparam logic [4:0] PH_IRQ = 5'h1C;
  localparam logic [2:0] SAVED_NONE = 3'h7;
  // architectural indices
  localparam logic [3:0] IDX_BANK_LO = 4'h8;
  localparam logic [3:0] IDX_SP = 4'hD;
  localparam logic [3:0] IDX_LINK = 4'hE;
  localparam logic [3:0] IDX_PC = 4'hF;
  // reset values and fetch steps
  localparam logic [31:0] CSW_RST = 32'h000000D3;
  localparam logic [31:0] PC_RST = 32'h00000000;
  localparam logic [31:0] STEP_WIDE = 32'h00000004;
  localparam logic [31:0] STEP_COMPACT = 32'h00000002;
  // exception vectors
  localparam logic [31:0] VEC_UND = 32'h00000004;
  localparam logic [31:0] VEC_TRAP = 32'h00000008;
  localparam logic [31:0] VEC_ABT = 32'h00000010;
  localparam logic [31:0] VEC_IRQ = 32'h00000018;
  localparam logic [31:0] VEC_FAST = 32'h0000001C;
  // access sizes and condition codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [3:0] COND_AL = 4'hE;
  // bus register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CSW = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_PEND = 8'h0C;
  localparam logic [7:0] ADDR_PEEK_IDX = 8'h10;
  localparam logic [7:0] ADDR_PEEK_DATA = 8'h14;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int CTRL_EXC_EN = 0;
  localparam int CTRL_ALIGN_AB = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status word layout
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic [19:0] rsv;
    logic irq_off;
    logic fast_off;
    logic compact;
    logic [4:0] mode;
  } bmx_csw_s;
  // exception requests, one bit per class
  typedef struct packed {
    logic abort;
    logic fast;
    logic irq;
    logic bad_op;
    logic trap;
  } bmx_exc_s;
endpackage : bmx_pkg

/* File: testbench/bmx_src_model.sv */
// bmx_src_model: interrupt and abort sources beside the core
`timescale 1ns/1ps
`default_nettype none
module bmx_src_model
  import bmx_pkg::*;
(
  input wire logic irq_lvl, // interrupt line, level
  input wire logic fast_lvl, // fast interrupt line, level
  input wire logic [2:0] evt, // abort, undefined-op, trap pulses
  output var bmx_exc_s exc_req // requests to the core
);
  assign exc_req = {evt[2], fast_lvl, irq_lvl, evt[1:0]};
endmodule : bmx_src_model
`default_nettype wire

/* File: testbench/test_banked_mode_register_exception_unit.sv */
// test_banked_mode_register_exception_unit: directed bench of the banked register unit
`timescale 1ns/1ps
`default_nettype none
module test_banked_mode_register_exception_unit;
  import bmx_pkg::*;
  logic clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic wr_en, link_en, pc_step, csw_we, ret_dp, irq_lvl, iv, mreq, priv, taken, cpass, afault;
  logic fast_lvl, rmul, half;
  logic [7:0] awaddr, araddr;
  logic [3:0] wr_idx, ra_idx;
  logic [2:0] evt;
  logic [1:0] bresp, rresp, msz;
  logic [31:0] wdata, rdata, wr_data, ins, maddr, pc, ra_data, got;
  bmx_csw_s csw, csw_wdata;
  bmx_exc_s exc_req, exc_class;
  int err_count = 0;
  int check_count = 0;
  bmx_src_model src (.irq_lvl(irq_lvl), .fast_lvl(fast_lvl), .evt(evt), .exc_req(exc_req));
  bmx_core_regs uut (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(awvalid), .s_axi_awaddr(awaddr),
    .s_axi_awready(awready), .s_axi_wvalid(wvalid), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bresp(bresp), .s_axi_bready(bready),
    .s_axi_arvalid(arvalid), .s_axi_araddr(araddr), .s_axi_arready(arready), .s_axi_rvalid(rvalid),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rready(rready), .rd_a_idx(ra_idx), .rd_b_idx(4'h0),
    .rd_a_data(ra_data), .rd_b_data(), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .link_en(link_en),
    .pc_step(pc_step), .csw_we(csw_we), .csw_wdata(csw_wdata), .ret_dp(ret_dp), .ret_multi(rmul),
    .exc_req(exc_req), .instr_valid(iv), .instr(ins), .mem_req(mreq), .mem_addr(maddr), .mem_size(msz),
    .pc(pc), .csw(csw), .privileged(priv), .fetch_half(half), .cond_pass(cpass), .align_fault(afault),
    .exc_taken(taken), .exc_class(exc_class));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // one bus transfer; each channel drops valid at the edge it is taken
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    {awaddr, araddr, wdata} <= {a, a, d};
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (arvalid && arready) arvalid <= 0;
      if ((bvalid && bready) || (rvalid && rready)) break;
    end
    if (n == 100) begin
      err_count++;
      wrap_up();
    end else begin
      {bready, rready} <= 2'h0;
      got = rdata;
      chk({30'h0, w ? bresp : rresp}, {30'h0, er});
    end
  endtask : axi
  // pulses last one cycle, then outputs settle
  task automatic tick;
    @(posedge clk);
    {wr_en, link_en, pc_step, csw_we, ret_dp, irq_lvl, iv, mreq, evt, fast_lvl, rmul} <= '0;
    #1;
  endtask : tick
  task automatic rreg(input logic [3:0] i);
    @(posedge clk);
    ra_idx <= i;
    @(posedge clk);
    #1;
    got = ra_data;
  endtask : rreg
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, wr_en, link_en, pc_step, csw_we, ret_dp, fast_lvl, rmul} <= '0;
    {irq_lvl, iv, mreq, evt, awaddr, araddr, wr_idx, ra_idx, msz, wdata, wr_data, ins, maddr, csw_wdata} <= '0;
    repeat (16) @(posedge clk);
    reset_n <= 1;
    #1;
    chk(csw, CSW_RST);
    chk({31'h0, priv}, 32'h1);
    axi(1'b0, ADDR_CSW, 32'h0, RESP_OKAY);
    chk(got, CSW_RST);
    axi(1'b0, 8'hFC, 32'h0, RESP_SLVERR);
    axi(1'b1, ADDR_CSW, 32'h0, RESP_SLVERR);
    $display("test reset done");
    @(posedge clk);
    {wr_en, wr_idx, wr_data} <= {1'b1, IDX_SP, 32'h1300};
    tick();
    axi(1'b1, ADDR_PEEK_IDX, {27'h0, PH_SUP}, RESP_OKAY);
    axi(1'b0, ADDR_PEEK_DATA, 32'h0, RESP_OKAY);
    chk(got, 32'h1300);
    @(posedge clk);
    {wr_en, wr_idx, wr_data, csw_we, csw_wdata} <= {1'b1, 4'h0, 32'hA5, 1'b1, 32'h10};
    tick();
    chk({31'h0, priv}, 32'h0);
    rreg(IDX_SP);
    chk(got, 32'h0);
    rreg(4'h0);
    chk(got, 32'hA5);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      {iv, ins, mreq, maddr} <= {1'b1, k ? 32'h0 : {COND_AL, 28'h0}, 1'b1, 32'h2};
      msz <= k ? SZ_HALF : SZ_WORD;
      tick();
      chk({30'h0, cpass, afault}, k ? 32'h0 : 32'h3);
    end
    @(posedge clk);
    pc_step <= 1;
    tick();
    chk(pc, STEP_WIDE);
    @(posedge clk);
    irq_lvl <= 1;
    tick();
    chk(csw, 32'h92);
    chk(pc, VEC_IRQ);
    chk({26'h0, taken, exc_class}, 32'h24);
    rreg(IDX_LINK);
    chk(got, 32'h8);
    @(posedge clk);
    ret_dp <= 1;
    tick();
    chk(csw, 32'h10);
    chk(pc, 32'h8);
    @(posedge clk);
    link_en <= 1;
    tick();
    rreg(IDX_LINK);
    chk(got, 32'hC);
    @(posedge clk);
    evt <= 3'h5;
    tick();
    chk(csw, 32'h94);
    for (int k = 0; k < 4 && csw.mode !== MODE_SUP; k++) begin
      @(posedge clk);
      #1;
    end
    chk({27'h0, csw.mode}, {27'h0, MODE_SUP});
    chk(pc, VEC_TRAP);
    $display("test exceptions done");
    @(posedge clk);
    {csw_we, csw_wdata} <= {1'b1, 32'h33};
    tick();
    @(posedge clk);
    {pc_step, iv, ins} <= {1'b1, 1'b1, 32'h0};
    tick();
    chk({30'h0, half, cpass}, 32'h3);
    chk(pc, VEC_TRAP + STEP_COMPACT);
    @(posedge clk);
    fast_lvl <= 1;
    tick();
    chk(csw, 32'hD1);
    chk({26'h0, taken, exc_class}, 32'h28);
    @(posedge clk);
    {wr_en, wr_idx, wr_data} <= {1'b1, IDX_BANK_LO, 32'h88};
    tick();
    rreg(IDX_BANK_LO);
    chk(got, 32'h88);
    rreg(IDX_LINK);
    chk(got, 32'hC);
    @(posedge clk);
    rmul <= 1;
    tick();
    chk(csw, 32'h33);
    chk(pc, 32'hC);
    rreg(IDX_BANK_LO);
    chk(got, 32'h0);
    axi(1'b1, ADDR_CTRL, 32'h3, RESP_OKAY);
    axi(1'b0, ADDR_CTRL, 32'h0, RESP_OKAY);
    chk(got, 32'h3);
    @(posedge clk);
    {mreq, maddr, msz} <= {1'b1, 32'h2, SZ_WORD};
    tick();
    chk(csw, 32'h94);
    $display("test fast and compact done");
    wrap_up();
  end
endmodule : test_banked_mode_register_exception_unit
`default_nettype wire
